/* File: design/tlvic_cfg.svh */
// Constants of the two-level vectored interrupt controller: register offsets, fields, resets
// Assumes inclusion by the package only; the design file uses its macros without including it
`ifndef TLVIC_CFG_SVH
`define TLVIC_CFG_SVH
`define TLVIC_NUM_SRC 11
`define TLVIC_CLK_PER_MC 4
`define TLVIC_OFS_IRQ_ENABLE 32'h0000_0000
`define TLVIC_OFS_EXT_IRQ_ENABLE 32'h0000_0004
`define TLVIC_OFS_IRQ_PRIORITY 32'h0000_0008
`define TLVIC_OFS_EXT_IRQ_PRIORITY 32'h0000_000C
`define TLVIC_OFS_TIMER_CONTROL 32'h0000_0010
`define TLVIC_OFS_EXT_IRQ_FLAG 32'h0000_0014
`define TLVIC_OFS_WATCHDOG_CONTROL 32'h0000_0018
`define TLVIC_OFS_SERIAL_CONTROL 32'h0000_001C
`define TLVIC_OFS_CID_FLAGS 32'h0000_0020
`define TLVIC_OFS_STATUS 32'h0000_0024
`define TLVIC_IE_GLOBAL_BIT 7
`define TLVIC_TIMER_CONTROL_REG_IT0_BIT 0
`define TLVIC_TIMER_CONTROL_REG_IE0_BIT 1
`define TLVIC_TIMER_CONTROL_REG_IT1_BIT 2
`define TLVIC_TIMER_CONTROL_REG_IE1_BIT 3
`define TLVIC_TIMER_CONTROL_REG_TF0_BIT 5
`define TLVIC_TIMER_CONTROL_REG_TF1_BIT 7
`define TLVIC_WATCHDOG_CONTROL_REG_FLAG_BIT 3
`define TLVIC_SCON_FLAG_BIT 7
`define TLVIC_EXT_IRQ_FLAG_REG_CID_BIT 2
`define TLVIC_RESET_BYTE 8'h00
`define TLVIC_CID_WIDTH 8
`define TLVIC_VEC_EXT0 16'h0003
`define TLVIC_VEC_TMR0 16'h000B
`define TLVIC_VEC_EXT1 16'h0013
`define TLVIC_VEC_TMR1 16'h001B
`define TLVIC_VEC_SER 16'h003B
`define TLVIC_VEC_EXT2 16'h0043
`define TLVIC_VEC_EXT3 16'h004B
`define TLVIC_VEC_CID 16'h0053
`define TLVIC_VEC_DIV 16'h005B
`define TLVIC_VEC_CMP 16'h0063
`define TLVIC_VEC_WDT 16'h006B
`endif

/* File: design/tlvic_ctrl.sv */
// Two-level vectored interrupt controller with AHB-Lite register slave
// Assumes one hclk domain; core status and peripheral events are synchronous, pins are not
//
// Implementation choices: the address map and the AHB-Lite slave port.
`default_nettype none
module tlvic_ctrl
	import tlvic_pkg::*;
#(
	parameter int NUM_SRC = `TLVIC_NUM_SRC,
	parameter int CLK_PER_MC = `TLVIC_CLK_PER_MC
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_req_pin_zero,
	input wire logic ext_req_pin_one,
	input wire logic ext_req_pin_two,
	input wire logic ext_req_pin_three,
	input wire logic comparator_result,
	input wire tlvic_pkg::tlvic_evt_t evt,
	input wire tlvic_pkg::tlvic_core_t core,
	output tlvic_pkg::tlvic_call_t call,
	output logic [1:0] in_service
);
	import tlvic_pkg::*;

	initial
	begin
		if (NUM_SRC != `TLVIC_NUM_SRC || CLK_PER_MC < 1 || CLK_PER_MC > 255)
			$error("tlvic_ctrl: unsupported parameter values");
	end

	localparam logic [15:0] VEC [0:10] = '{`TLVIC_VEC_EXT0, `TLVIC_VEC_TMR0, `TLVIC_VEC_EXT1,
		`TLVIC_VEC_TMR1, `TLVIC_VEC_SER, `TLVIC_VEC_EXT2, `TLVIC_VEC_EXT3, `TLVIC_VEC_CID,
		`TLVIC_VEC_DIV, `TLVIC_VEC_CMP, `TLVIC_VEC_WDT};

	// Machine-cycle enable
	logic [7:0] mc_cnt_q;
	logic mc_tick;
	assign mc_tick = (mc_cnt_q == 8'(CLK_PER_MC - 1));
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mc_cnt_q <= 8'h00;
		else if (mc_tick)
			mc_cnt_q <= 8'h00;
		else
			mc_cnt_q <= mc_cnt_q + 8'h01;
	end

	// Pin synchronisers, two flops each
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1_q <= 5'h0F;
			pin_s2_q <= 5'h0F;
		end
		else
		begin
			pin_s1_q <= {comparator_result, ext_req_pin_three, ext_req_pin_two, ext_req_pin_one,
				ext_req_pin_zero};
			pin_s2_q <= pin_s1_q;
		end
	end

	// Per machine cycle samples
	logic [4:0] samp_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			samp_q <= 5'h0F;
		else if (mc_tick)
			samp_q <= pin_s2_q;
	end
	logic [3:0] pin_fall;
	logic cmp_rise;
	assign pin_fall = mc_tick ? (samp_q[3:0] & ~pin_s2_q[3:0]) : 4'h0;
	assign cmp_rise = mc_tick & ~samp_q[4] & pin_s2_q[4];

	// Registers
	logic [7:0] irq_enable_reg_q;
	logic [7:0] ext_irq_enable_reg_q;
	logic [7:0] irq_priority_reg_q;
	logic [7:0] ext_irq_priority_reg_q;
	logic ext_zero_trigger_type_q;
	logic ext_one_trigger_type_q;
	logic [NUM_SRC-1:0] flag_q;
	logic [`TLVIC_CID_WIDTH-1:0] cid_flags_q;
	logic [1:0] in_service_q;
	logic caller_id_summary_flag;
	assign caller_id_summary_flag = |cid_flags_q;

	// Bus address phase capture
	logic wr_pend_q;
	logic [31:0] wr_addr_q;
	logic [31:0] rd_data_q;
	logic bus_acc;
	assign bus_acc = hsel & hready & htrans[1];
	logic wr_ie;
	logic wr_eie;
	logic wr_timer_control_reg;
	logic wr_ext_irq_flag_reg;
	logic wr_watchdog_control_reg;
	logic wr_scon;
	logic wr_cid;
	assign wr_ie = wr_pend_q && wr_addr_q == `TLVIC_OFS_IRQ_ENABLE;
	assign wr_eie = wr_pend_q && wr_addr_q == `TLVIC_OFS_EXT_IRQ_ENABLE;
	assign wr_timer_control_reg = wr_pend_q && wr_addr_q == `TLVIC_OFS_TIMER_CONTROL;
	assign wr_ext_irq_flag_reg = wr_pend_q && wr_addr_q == `TLVIC_OFS_EXT_IRQ_FLAG;
	assign wr_watchdog_control_reg = wr_pend_q && wr_addr_q == `TLVIC_OFS_WATCHDOG_CONTROL;
	assign wr_scon = wr_pend_q && wr_addr_q == `TLVIC_OFS_SERIAL_CONTROL;
	assign wr_cid = wr_pend_q && wr_addr_q == `TLVIC_OFS_CID_FLAGS;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_q <= bus_acc & hwrite;
			wr_addr_q <= {haddr[31:2], 2'b00};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_enable_reg_q <= `TLVIC_RESET_BYTE;
			ext_irq_enable_reg_q <= `TLVIC_RESET_BYTE;
			irq_priority_reg_q <= `TLVIC_RESET_BYTE;
			ext_irq_priority_reg_q <= `TLVIC_RESET_BYTE;
			ext_zero_trigger_type_q <= 1'b0;
			ext_one_trigger_type_q <= 1'b0;
		end
		else if (wr_pend_q)
		begin
			if (wr_ie)
				irq_enable_reg_q <= hwdata[7:0];
			if (wr_eie)
				ext_irq_enable_reg_q <= hwdata[7:0];
			if (wr_addr_q == `TLVIC_OFS_IRQ_PRIORITY)
				irq_priority_reg_q <= hwdata[7:0];
			if (wr_addr_q == `TLVIC_OFS_EXT_IRQ_PRIORITY)
				ext_irq_priority_reg_q <= hwdata[7:0];
			if (wr_timer_control_reg)
			begin
				ext_zero_trigger_type_q <= hwdata[`TLVIC_TIMER_CONTROL_REG_IT0_BIT];
				ext_one_trigger_type_q <= hwdata[`TLVIC_TIMER_CONTROL_REG_IT1_BIT];
			end
		end
	end

	// Per-source enable and priority bit, in hierarchy order
	logic [NUM_SRC-1:0] src_en;
	logic [NUM_SRC-1:0] src_hi;
	assign src_en = {ext_irq_enable_reg_q[5:0], irq_enable_reg_q[6], irq_enable_reg_q[3:0]};
	assign src_hi = {ext_irq_priority_reg_q[5:0], irq_priority_reg_q[6], irq_priority_reg_q[3:0]};

	// Software write of flag bits, per source
	logic [NUM_SRC-1:0] sw_wr;
	logic [NUM_SRC-1:0] sw_val;
	assign sw_wr = {wr_watchdog_control_reg, {5{wr_ext_irq_flag_reg}}, wr_scon, {4{wr_timer_control_reg}}};
	assign sw_val = {hwdata[`TLVIC_WATCHDOG_CONTROL_REG_FLAG_BIT], hwdata[4:3], 1'b0, hwdata[1:0],
		hwdata[`TLVIC_SCON_FLAG_BIT], hwdata[`TLVIC_TIMER_CONTROL_REG_TF1_BIT], hwdata[`TLVIC_TIMER_CONTROL_REG_IE1_BIT],
		hwdata[`TLVIC_TIMER_CONTROL_REG_TF0_BIT], hwdata[`TLVIC_TIMER_CONTROL_REG_IE0_BIT]};

	// Hardware set events per source
	logic [NUM_SRC-1:0] hw_set;
	assign hw_set[TLVIC_SRC_EXT0] = ext_zero_trigger_type_q ? pin_fall[0] : 1'b0;
	assign hw_set[TLVIC_SRC_TMR0] = evt.timer_zero_overflow;
	assign hw_set[TLVIC_SRC_EXT1] = ext_one_trigger_type_q ? pin_fall[1] : 1'b0;
	assign hw_set[TLVIC_SRC_TMR1] = evt.timer_one_overflow;
	assign hw_set[TLVIC_SRC_SER] = evt.serial_event;
	assign hw_set[TLVIC_SRC_EXT2] = pin_fall[2];
	assign hw_set[TLVIC_SRC_EXT3] = pin_fall[3];
	assign hw_set[TLVIC_SRC_CID] = 1'b0;
	assign hw_set[TLVIC_SRC_DIV] = evt.divider_overflow;
	assign hw_set[TLVIC_SRC_CMP] = cmp_rise;
	assign hw_set[TLVIC_SRC_WDT] = evt.watchdog_timeout;

	// Call clears: edge externals, timers, serial, divider, comparator
	logic [NUM_SRC-1:0] auto_clr_ok;
	assign auto_clr_ok = {1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, ext_one_trigger_type_q, 1'b1,
		ext_zero_trigger_type_q};

	// Arbitration
	logic [NUM_SRC-1:0] req;
	logic [NUM_SRC-1:0] clr_call;
	logic any_hi;
	logic any_lo;
	logic [3:0] win_hi;
	logic [3:0] win_lo;
	logic take;
	logic take_hi;
	logic [3:0] win;
	always_comb
	begin
		req = flag_q & src_en & {NUM_SRC{irq_enable_reg_q[`TLVIC_IE_GLOBAL_BIT]}};
		req[TLVIC_SRC_EXT0] = irq_enable_reg_q[`TLVIC_IE_GLOBAL_BIT] & src_en[0] &
			(ext_zero_trigger_type_q ? flag_q[0] : ~pin_s2_q[0]);
		req[TLVIC_SRC_EXT1] = irq_enable_reg_q[`TLVIC_IE_GLOBAL_BIT] & src_en[2] &
			(ext_one_trigger_type_q ? flag_q[2] : ~pin_s2_q[1]);
		req[TLVIC_SRC_CID] = irq_enable_reg_q[`TLVIC_IE_GLOBAL_BIT] & src_en[7] & caller_id_summary_flag;
		any_hi = 1'b0;
		any_lo = 1'b0;
		win_hi = 4'h0;
		win_lo = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (req[i] && src_hi[i])
			begin
				any_hi = 1'b1;
				win_hi = 4'(i);
			end
			if (req[i] && !src_hi[i])
			begin
				any_lo = 1'b1;
				win_lo = 4'(i);
			end
		end
		take_hi = any_hi & ~in_service_q[1];
		take = mc_tick & core.last_cycle & ~core.writes_enable_or_priority & ~core.is_return_from_interrupt &
			(take_hi | (any_lo & ~|in_service_q));
		win = take_hi ? win_hi : win_lo;
		clr_call = '0;
		if (take)
			clr_call[win] = auto_clr_ok[win];
	end

	// Flags: hardware set wins over any clear
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : g_flag
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					flag_q[g] <= 1'b0;
				else if (hw_set[g])
					flag_q[g] <= 1'b1;
				else if (clr_call[g])
					flag_q[g] <= 1'b0;
				else if (sw_wr[g])
					flag_q[g] <= sw_val[g];
			end
		end
	endgenerate

	// CID event flags, software clears by writing one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cid_flags_q <= '0;
		else
			cid_flags_q <= evt.cid_event | (cid_flags_q & ~(wr_cid ? hwdata[`TLVIC_CID_WIDTH-1:0] : '0));
	end

	// In-service tracking
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			in_service_q <= 2'b00;
		else if (take)
			in_service_q[take_hi] <= 1'b1;
		else if (core.is_return_from_interrupt && core.last_cycle && mc_tick)
		begin
			if (in_service_q[1])
				in_service_q[1] <= 1'b0;
			else
				in_service_q[0] <= 1'b0;
		end
	end

	// Call output
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			call <= '0;
		else
		begin
			call.long_call <= take;
			if (take)
			begin
				call.vector <= VEC[win];
				call.level_high <= take_hi;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			in_service <= 2'b00;
		else
			in_service <= in_service_q;
	end

	// Read mux
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case ({haddr[31:2], 2'b00})
			`TLVIC_OFS_IRQ_ENABLE: rd_mux[7:0] = irq_enable_reg_q;
			`TLVIC_OFS_EXT_IRQ_ENABLE: rd_mux[7:0] = ext_irq_enable_reg_q;
			`TLVIC_OFS_IRQ_PRIORITY: rd_mux[7:0] = irq_priority_reg_q;
			`TLVIC_OFS_EXT_IRQ_PRIORITY: rd_mux[7:0] = ext_irq_priority_reg_q;
			`TLVIC_OFS_TIMER_CONTROL: rd_mux[7:0] = {flag_q[3], 1'b0, flag_q[1], 1'b0, flag_q[2],
				ext_one_trigger_type_q, flag_q[0], ext_zero_trigger_type_q};
			`TLVIC_OFS_EXT_IRQ_FLAG: rd_mux[7:0] = {3'b000, flag_q[9:8], caller_id_summary_flag, flag_q[6:5]};
			`TLVIC_OFS_WATCHDOG_CONTROL: rd_mux[`TLVIC_WATCHDOG_CONTROL_REG_FLAG_BIT] = flag_q[10];
			`TLVIC_OFS_SERIAL_CONTROL: rd_mux[`TLVIC_SCON_FLAG_BIT] = flag_q[4];
			`TLVIC_OFS_CID_FLAGS: rd_mux[`TLVIC_CID_WIDTH-1:0] = cid_flags_q;
			`TLVIC_OFS_STATUS: rd_mux[1:0] = in_service_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_data_q <= 32'h0000_0000;
		else if (bus_acc && !hwrite)
			rd_data_q <= rd_mux;
	end
	assign hrdata = rd_data_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
endmodule : tlvic_ctrl
`default_nettype wire

/* File: design/tlvic_pkg.sv */
// Types of the two-level vectored interrupt controller
// Assumes tlvic_cfg.svh is on the include path
`default_nettype none
package tlvic_pkg;
	`include "tlvic_cfg.svh"
	typedef enum logic [3:0]
	{
		TLVIC_SRC_EXT0 = 4'h0,
		TLVIC_SRC_TMR0 = 4'h1,
		TLVIC_SRC_EXT1 = 4'h2,
		TLVIC_SRC_TMR1 = 4'h3,
		TLVIC_SRC_SER = 4'h4,
		TLVIC_SRC_EXT2 = 4'h5,
		TLVIC_SRC_EXT3 = 4'h6,
		TLVIC_SRC_CID = 4'h7,
		TLVIC_SRC_DIV = 4'h8,
		TLVIC_SRC_CMP = 4'h9,
		TLVIC_SRC_WDT = 4'hA
	} tlvic_src_t;
	typedef enum logic [1:0]
	{
		TLVIC_ST_RUN = 2'b00,
		TLVIC_ST_CALL = 2'b01
	} tlvic_state_t;
	// Events from peripherals, one-cycle pulses on hclk
	typedef struct packed
	{
		logic timer_zero_overflow;
		logic timer_one_overflow;
		logic serial_event;
		logic divider_overflow;
		logic watchdog_timeout;
		logic [`TLVIC_CID_WIDTH-1:0] cid_event;
	} tlvic_evt_t;
	// Instruction status from the CPU core
	typedef struct packed
	{
		logic last_cycle;
		logic writes_enable_or_priority;
		logic is_return_from_interrupt;
	} tlvic_core_t;
	// Vectored call request to the CPU core
	typedef struct packed
	{
		logic long_call;
		logic [15:0] vector;
		logic level_high;
	} tlvic_call_t;
endpackage : tlvic_pkg
`default_nettype wire

/* File: test/tlvic_core_model.sv */
// CPU core stand-in: instruction status seen by the interrupt controller
// Assumes return_from_interrupt_go pulses one cycle; stall and wr_ctl are held levels
`default_nettype none
module tlvic_core_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic return_from_interrupt_go,
	input wire logic stall,
	input wire logic wr_ctl,
	output tlvic_pkg::tlvic_core_t core
);
	import tlvic_pkg::*;
	logic [2:0] return_from_interrupt_q;
	// Return spans one machine cycle so exactly one tick sees it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			return_from_interrupt_q <= 3'h0;
			core <= '0;
		end
		else
		begin
			return_from_interrupt_q <= return_from_interrupt_go ? 3'h4 : return_from_interrupt_q - {2'h0, return_from_interrupt_q != 3'h0};
			core.is_return_from_interrupt <= return_from_interrupt_go || return_from_interrupt_q > 3'h1;
			core.last_cycle <= !stall;
			core.writes_enable_or_priority <= wr_ctl;
		end
	end
endmodule : tlvic_core_model
`default_nettype wire

/* File: test/tlvic_ctrl_sva.sv */
// Checker of the interrupt controller: call timing, gating, vectors and in-service bits
// Assumes a bind onto tlvic_ctrl, one hclk domain
`default_nettype none
module tlvic_ctrl_sva
#(
	parameter int NUM_SRC = 11,
	parameter int CLK_PER_MC = 4
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic ext_req_pin_zero,
	input wire logic ext_req_pin_one,
	input wire logic ext_req_pin_two,
	input wire logic ext_req_pin_three,
	input wire logic comparator_result,
	input wire tlvic_pkg::tlvic_evt_t evt,
	input wire tlvic_pkg::tlvic_core_t core,
	input wire tlvic_pkg::tlvic_call_t call,
	input wire logic [1:0] in_service
);
	import tlvic_pkg::*;
	logic wr_ie_q;
	logic glob_q;
	// Shadow of the global enable, updated in the write data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ie_q <= 1'b0;
			glob_q <= 1'b0;
		end
		else
		begin
			wr_ie_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0000;
			if (wr_ie_q)
				glob_q <= hwdata[7];
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_gap;
		call.long_call |=> !call.long_call [*3];
	endproperty
	a_gap: assert property (p_gap) else $error("call gap");
	property p_glob;
		call.long_call |-> $past(glob_q);
	endproperty
	a_glob: assert property (p_glob) else $error("call while disabled");
	property p_cond;
		call.long_call |-> $past(core.last_cycle) && !$past(core.is_return_from_interrupt) && !$past(core.writes_enable_or_priority);
	endproperty
	a_cond: assert property (p_cond) else $error("call off boundary");
	property p_vec;
		call.long_call |-> call.vector inside {[16'h0003:16'h001B], [16'h003B:16'h006B]} && call.vector[2:0] == 3'h3;
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_pre;
		call.long_call |-> !in_service[1] && (call.level_high || !in_service[0]);
	endproperty
	a_pre: assert property (p_pre) else $error("bad preemption");
	property p_set;
		call.long_call |=> in_service[call.level_high];
	endproperty
	a_set: assert property (p_set) else $error("level not marked");
	property p_rhi;
		$rose(in_service[1]) |-> $past(call.long_call) && call.level_high;
	endproperty
	a_rhi: assert property (p_rhi) else $error("high set without call");
	property p_rlo;
		$rose(in_service[0]) |-> $past(call.long_call) && !call.level_high;
	endproperty
	a_rlo: assert property (p_rlo) else $error("low set without call");
	property p_fhi;
		$fell(in_service[1]) |-> $past(core.is_return_from_interrupt) || $past(core.is_return_from_interrupt, 2) || $past(core.is_return_from_interrupt, 3);
	endproperty
	a_fhi: assert property (p_fhi) else $error("high ended without return");
	property p_flo;
		$fell(in_service[0]) |-> !$past(in_service[1]) && ($past(core.is_return_from_interrupt) || $past(core.is_return_from_interrupt, 2));
	endproperty
	a_flo: assert property (p_flo) else $error("low ended wrongly");
	c_high: cover property (call.long_call && call.level_high);
	c_pre: cover property (call.long_call && call.level_high && in_service[0]);
	c_ret: cover property ($fell(in_service[0]));
endmodule : tlvic_ctrl_sva
`default_nettype wire

/* File: test/tlvic_ctrl_test.sv */
// Self-checking bench of the interrupt controller with a core stand-in and a bound checker
// Assumes package, design, core model and checker compiled first
`default_nettype none
module tlvic_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tlvic_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic hreadyout;
	logic hresp;
	logic [3:0] pin = 4'hF;
	logic cmp = 1'b0;
	logic return_from_interrupt_go = 1'b0;
	logic stall = 1'b0;
	logic wr_ctl = 1'b0;
	tlvic_evt_t evt = '0;
	tlvic_core_t core;
	tlvic_call_t call;
	logic [1:0] in_service;
	logic [16:0] calls[$];
	logic [15:0] vec[11] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0043, 16'h004B, 16'h0053,
		16'h005B, 16'h0063, 16'h006B};
	logic [15:0] lfsr = 16'h8EB5;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int isv = 0;
	tlvic_ctrl #(.NUM_SRC(11), .CLK_PER_MC(4)) tlvic_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_req_pin_zero(pin[0]), .ext_req_pin_one(pin[1]),
		.ext_req_pin_two(pin[2]), .ext_req_pin_three(pin[3]), .comparator_result(cmp), .evt(evt), .core(core),
		.call(call), .in_service(in_service));
	tlvic_core_model tlvic_core_model_inst (.hclk(hclk), .hresetn(hresetn), .return_from_interrupt_go(return_from_interrupt_go), .stall(stall),
		.wr_ctl(wr_ctl), .core(core));
	initial
		forever #10 hclk = ~hclk;
	task automatic end_of_test();
		$display("Counts: checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// Records every call and cuts a hang short
	always @(posedge hclk)
	begin
		cycles++;
		if (call.long_call === 1'b1)
			calls.push_back({call.level_high, call.vector});
		if (cycles == 20000)
		begin
			failures++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		haddr <= 32'(a);
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= 32'(d);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		chk(32'(hresp), 32'h0000_0000);
		if (!w)
			chk(hrdata, 32'(e));
	endtask : bus
	task automatic fire(input logic [10:0] m);
		pin <= ~{m[6], m[5], m[2], m[0]};
		cmp <= m[9];
		evt <= {m[1], m[3], m[4], m[8], m[10], 7'h00, m[7]};
		@(posedge hclk);
		evt <= '0;
		repeat (8) @(posedge hclk);
		pin <= 4'hF;
		cmp <= 1'b0;
		repeat (12) @(posedge hclk);
	endtask : fire
	task automatic take(input int s, input logic hi);
		repeat (60) if (calls.size() == 0) @(posedge hclk);
		chk(calls.size() > 0 ? calls.pop_front() : '1, {hi, vec[s]});
		isv = isv | (hi ? 2 : 1);
		repeat (2) @(posedge hclk);
		chk(in_service, isv[1:0]);
	endtask : take
	task automatic return_from_interrupt();
		return_from_interrupt_go <= 1'b1;
		@(posedge hclk);
		return_from_interrupt_go <= 1'b0;
		repeat (6) @(posedge hclk);
		isv = isv[1] ? isv & 1 : 0;
		chk(in_service, isv[1:0]);
	endtask : return_from_interrupt
	task automatic no_call(input int n);
		repeat (n) @(posedge hclk);
		chk(calls.size(), 0);
		calls.delete();
	endtask : no_call
	initial
	begin
		logic [10:0] m;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, 8'h00, 8'h00, 8'h00);
		bus(1, 8'h0C, 8'h3F, 8'h00);
		bus(0, 8'h0C, 8'h00, 8'h3F);
		bus(1, 8'h40, 8'hFF, 8'h00);
		bus(0, 8'h40, 8'h00, 8'h00);
		bus(1, 8'h0C, 8'h00, 8'h00);
		bus(1, 8'h04, 8'h3F, 8'h00);
		bus(1, 8'h10, 8'h05, 8'h00);
		for (int r = 0; r < 3; r++)
		begin
			lfsr = lfsr_next(lfsr);
			m = r == 0 ? 11'h7FF : lfsr[10:0];
			bus(1, 8'h00, 8'h4F, 8'h00);
			fire(m);
			no_call(8);
			bus(1, 8'h00, 8'hCF, 8'h00);
			for (int s = 0; s < 11; s++)
			begin
				if (m[s])
				begin
					take(s, 1'b0);
					if (s == 7)
					begin
						bus(0, 8'h14, 8'h00, {3'h0, m[9], m[8], 3'h4});
						bus(1, 8'h20, 8'hFF, 8'h00);
					end
					if (s == 10)
						bus(1, 8'h18, 8'h00, 8'h00);
					return_from_interrupt();
				end
			end
			no_call(24);
		end
		bus(1, 8'h10, 8'h00, 8'h00);
		bus(1, 8'h00, 8'h81, 8'h00);
		wr_ctl <= 1'b1;
		pin[0] <= 1'b0;
		no_call(16);
		wr_ctl <= 1'b0;
		take(0, 1'b0);
		return_from_interrupt();
		take(0, 1'b0);
		pin[0] <= 1'b1;
		return_from_interrupt();
		no_call(24);
		stall <= 1'b1;
		pin[0] <= 1'b0;
		repeat (12) @(posedge hclk);
		pin[0] <= 1'b1;
		repeat (12) @(posedge hclk);
		stall <= 1'b0;
		no_call(24);
		bus(1, 8'h10, 8'h05, 8'h00);
		bus(1, 8'h08, 8'h02, 8'h00);
		bus(1, 8'h00, 8'h8E, 8'h00);
		fire(11'h004);
		take(2, 1'b0);
		fire(11'h008);
		no_call(8);
		fire(11'h002);
		take(1, 1'b1);
		return_from_interrupt();
		no_call(12);
		return_from_interrupt();
		take(3, 1'b0);
		return_from_interrupt();
		end_of_test();
	end
endmodule : tlvic_ctrl_test
bind tlvic_ctrl tlvic_ctrl_sva #(.NUM_SRC(NUM_SRC), .CLK_PER_MC(CLK_PER_MC)) tlvic_ctrl_sva_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_req_pin_zero(ext_req_pin_zero),
	.ext_req_pin_one(ext_req_pin_one), .ext_req_pin_two(ext_req_pin_two), .ext_req_pin_three(ext_req_pin_three),
	.comparator_result(comparator_result), .evt(evt), .core(core), .call(call), .in_service(in_service));
`default_nettype wire
